// ===== src/flash_seq_map.vh
/*
  Constants for the program-Flash store sequencer: register offsets,
  field positions, reset values, array geometry and operation times.
  Assumes it is included by bare name from design files under src/.
*/
// What this block does
// - Flash programmable bytewise by debug port or stores
// - Programming only clears bits, never sets them
// - Erase sets a whole 512-byte page, or the whole 128-byte scratchpad, to FF
// - Hardware times erase 12 ms and write 50 us
// - Processor stalls; interrupts held until operation ends
// - Store write enable redirects data stores to Flash
// - Store write enable clears only by software
// - Data loads always go to external RAM
// - Code reads return Flash contents
// - Erase enable plus write enable: store erases page
// - Uninitialised Flash programmable only via debug port
// - Scratchpad select maps addresses 00-7F to scratchpad
// - Lock-byte page writable but software erase ignored
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH

// Register byte offsets on the APB bus.
`define PSC_OFF 8'h00
`define FSC_OFF 8'h04
`define STAT_OFF 8'h08

// Program store control fields.
`define PSC_WE_BIT 0
`define PSC_EE_BIT 1
`define PSC_SP_BIT 2
`define PSC_RESET 3'h0

// Flash scale control field.
`define FSC_ALLOW_BIT 0
`define FSC_RESET 1'h0

// Status fields.
`define STAT_BUSY_BIT 0
`define STAT_INIT_BIT 1
`define STAT_REFUSED_BIT 2

// Array geometry.
`define MAIN_BYTES 65536
`define SCRATCH_BYTES 128
`define PAGE_LAST 9'h1FF
`define SCRATCH_LAST 9'h07F
`define LOCK_PAGE 7'h7E
`define ERASED_BYTE 8'hFF

// Operation times, clock period and the 19-bit cycle counts they give.
`define PCLK_PERIOD_NS 25
`define ERASE_TIME_NS 12000000
`define WRITE_TIME_NS 50000
`define ERASE_CYCLES 19'h75300
`define WRITE_CYCLES 19'h007D0

`endif

// ===== src/flash_op_timer.v
/*
  Down-counter that times one Flash write or erase.
  Assumes start is a one-cycle pulse and load is at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_op_timer (
  // Clock, reset and enable.
  input wire pclk,
  input wire presetn,
  input wire ce,
  // Control.
  input wire start,
  input wire [18:0] load,
  // Status.
  output wire busy,
  output reg done
);
  reg [18:0] count_q; // Cycles left in the running operation.

  assign busy = (count_q != 19'h00000);

  // Load on start, count down, and pulse done on the last cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 19'h00000;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        count_q <= load;
      end else if (count_q != 19'h00000) begin
        count_q <= count_q - 19'h00001;
        if (count_q == 19'h00001) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule // flash_op_timer
`default_nettype wire

// ===== src/flash_byte_program_erase.v
/*
  Program-Flash store sequencer with its own 64 kB main array and a
  128-byte scratchpad. Redirects processor stores to Flash, times each
  write and erase, stalls the processor and holds interrupts meanwhile.
  Assumes one clock pclk, APB register access, and processor strobes
  that are single-cycle pulses issued only while cpu_stall is low.
*/
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.vh"
module flash_byte_program_erase #(
  parameter [18:0] ERASE_CYCLES = `ERASE_CYCLES,
  parameter [18:0] WRITE_CYCLES = `WRITE_CYCLES
) (
  // Clock, reset and enable.
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Processor data and code accesses.
  input wire [15:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire movx_wr,
  input wire movx_rd,
  input wire movc_rd,
  output reg [7:0] movc_rdata,
  output reg movc_valid,
  output wire cpu_stall,
  // Interrupt requests in and as passed on to the core.
  input wire [7:0] irq_in,
  output wire [7:0] irq_out,
  // External data RAM strobes.
  output reg external_data_ram_wr,
  output reg external_data_ram_rd,
  output reg [15:0] external_data_ram_addr,
  output reg [7:0] external_data_ram_wdata,
  // Debug-port programming.
  input wire dbg_wr,
  input wire dbg_erase,
  input wire dbg_scratch,
  input wire [15:0] dbg_addr,
  input wire [7:0] dbg_wdata,
  // Strap telling whether the array already holds a valid image.
  input wire flash_is_init
);
  // One-hot sequencer states.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PROG = 3'b010;
  localparam [2:0] ST_ERASE = 3'b100;

  // Storage arrays.
  reg [7:0] main_mem [0:`MAIN_BYTES-1]; // Main program array.
  reg [7:0] scratch_mem [0:`SCRATCH_BYTES-1]; // Scratchpad sector.

  // Software-visible control and status.
  reg store_write_enable_q; // Redirect stores to Flash.
  reg store_erase_enable_q; // Stores erase pages.
  reg scratchpad_select_q; // Low addresses reach scratchpad.
  reg flash_wr_erase_allow_q; // Master write/erase allow.
  reg refused_q; // A store was ignored.
  reg init_q; // Array holds a valid image.
  reg strap_done_q; // Strap has been sampled.

  // Sequencer state.
  reg [2:0] state_q; // Current state.
  reg [15:0] op_addr_q; // Target byte or page base.
  reg [7:0] op_data_q; // Byte being programmed.
  reg op_scratch_q; // Operation targets scratchpad.
  reg op_dbg_q; // Operation came from debug port.
  reg [8:0] walk_q; // Erase walk index.
  reg walk_done_q; // Whole page has been erased.
  reg [7:0] irq_held_q; // Interrupts caught during the stall.

  // Timer handshake.
  reg tmr_start; // Starts the operation timer.
  reg [18:0] tmr_load; // Timer length.
  wire tmr_busy; // Timer is running.
  wire tmr_done; // Timer finished this cycle.

  // Decode of requests in the idle state.
  wire idle = state_q[0];
  wire sw_flash = movx_wr && store_write_enable_q;
  wire sw_go = sw_flash && flash_wr_erase_allow_q && init_q;
  wire sw_erase = store_erase_enable_q;
  wire sw_sp = scratchpad_select_q && (cpu_addr[15:7] == 9'h000);
  wire sw_lock = (cpu_addr[15:9] == `LOCK_PAGE) && !sw_sp;
  wire dbg_go = dbg_wr || dbg_erase;
  wire sw_act = sw_go && !(sw_erase && sw_lock);
  wire refuse = idle && sw_flash && !sw_act && !dbg_go;

  // Code reads target scratchpad when selected.
  wire rd_sp = scratchpad_select_q && (cpu_addr[15:7] == 9'h000);

  // APB decode.
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite && ce;
  wire hit_psc = (paddr == `PSC_OFF);
  wire hit_fsc = (paddr == `FSC_OFF);
  wire hit_stat = (paddr == `STAT_OFF);
  wire hit_any = hit_psc || hit_fsc || hit_stat;

  assign pready = ce;
  assign pslverr = psel && penable && !hit_any;
  assign cpu_stall = !idle;
  // Interrupts stay hidden while stalled and are released together.
  assign irq_out = idle ? (irq_in | irq_held_q) : 8'h00;

  // Operation timer.
  flash_op_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(tmr_start),
    .load(tmr_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // Timer start and length chosen from the accepted request.
  always @* begin
    tmr_start = 1'b0;
    tmr_load = WRITE_CYCLES;
    if (idle && (dbg_go || sw_act)) begin
      tmr_start = 1'b1;
      if (dbg_go ? dbg_erase : sw_erase) begin
        tmr_load = ERASE_CYCLES;
      end
    end
  end

  // Register writes; the enable bits change only by software.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_write_enable_q <= 1'b0;
      store_erase_enable_q <= 1'b0;
      scratchpad_select_q <= 1'b0;
      flash_wr_erase_allow_q <= `FSC_RESET;
      refused_q <= 1'b0;
    end else if (ce) begin
      if (apb_wr && hit_psc) begin
        store_write_enable_q <= pwdata[`PSC_WE_BIT];
        store_erase_enable_q <= pwdata[`PSC_EE_BIT];
        scratchpad_select_q <= pwdata[`PSC_SP_BIT];
      end
      if (apb_wr && hit_fsc) begin
        flash_wr_erase_allow_q <= pwdata[`FSC_ALLOW_BIT];
      end
      // A new refusal wins over a software clear in the same cycle.
      if (refuse) begin
        refused_q <= 1'b1;
      end else if (apb_wr && hit_stat && pwdata[`STAT_REFUSED_BIT]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // Read data is prepared in the setup cycle, ready for the access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && apb_setup) begin
      if (hit_psc) begin
        prdata <= {29'h00000000, scratchpad_select_q,
                   store_erase_enable_q, store_write_enable_q};
      end else if (hit_fsc) begin
        prdata <= {31'h00000000, flash_wr_erase_allow_q};
      end else if (hit_stat) begin
        prdata <= {29'h00000000, refused_q, init_q, !idle};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Strap is sampled once after reset; a debug program marks it valid.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (ce) begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        init_q <= flash_is_init;
      end else if (idle && dbg_go) begin
        init_q <= 1'b1;
      end
    end
  end

  // Sequencer: accept, run the timed operation, then release the core.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      op_addr_q <= 16'h0000;
      op_data_q <= 8'h00;
      op_scratch_q <= 1'b0;
      op_dbg_q <= 1'b0;
      walk_q <= 9'h000;
      walk_done_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          walk_q <= 9'h000;
          walk_done_q <= 1'b0;
          // The debug port takes priority over a software store.
          if (dbg_go) begin
            op_addr_q <= dbg_addr;
            op_data_q <= dbg_wdata;
            op_scratch_q <= dbg_scratch;
            op_dbg_q <= 1'b1;
            state_q <= dbg_erase ? ST_ERASE : ST_PROG;
          end else if (sw_act) begin
            op_addr_q <= cpu_addr;
            op_data_q <= cpu_wdata;
            op_scratch_q <= sw_sp;
            op_dbg_q <= 1'b0;
            state_q <= sw_erase ? ST_ERASE : ST_PROG;
          end
        end
        ST_PROG: begin
          if (tmr_done || !tmr_busy) begin
            state_q <= ST_IDLE;
          end
        end
        ST_ERASE: begin
          // Walk the page one byte a cycle under the erase time.
          if (!walk_done_q) begin
            walk_q <= walk_q + 9'h001;
            if (walk_q == (op_scratch_q ? `SCRATCH_LAST : `PAGE_LAST)) begin
              walk_done_q <= 1'b1;
            end
          end
          if (walk_done_q && !tmr_busy) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Array updates; Flash contents have no reset.
  always @(posedge pclk) begin
    if (ce) begin
      if (state_q[1] && tmr_start == 1'b0 && tmr_busy && !walk_done_q) begin
        // Programming can only pull bits low.
        if (op_scratch_q) begin
          scratch_mem[op_addr_q[6:0]] <=
            scratch_mem[op_addr_q[6:0]] & op_data_q;
        end else begin
          main_mem[op_addr_q] <= main_mem[op_addr_q] & op_data_q;
        end
      end
      if (state_q[2] && !walk_done_q) begin
        if (op_scratch_q) begin
          scratch_mem[walk_q[6:0]] <= `ERASED_BYTE;
        end else begin
          main_mem[{op_addr_q[15:9], walk_q}] <= `ERASED_BYTE;
        end
      end
    end
  end

  // Interrupts arriving during a stall are held until the core is free.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_held_q <= 8'h00;
    end else if (ce) begin
      if (!idle) begin
        irq_held_q <= irq_held_q | irq_in;
      end else begin
        irq_held_q <= 8'h00;
      end
    end
  end

  // Code reads return the array byte one cycle later.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      movc_rdata <= 8'h00;
      movc_valid <= 1'b0;
    end else if (ce) begin
      movc_valid <= movc_rd && idle;
      if (movc_rd && idle) begin
        movc_rdata <= rd_sp ? scratch_mem[cpu_addr[6:0]]
                            : main_mem[cpu_addr];
      end
    end
  end

  // External RAM strobes for loads and for stores not sent to Flash.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_data_ram_wr <= 1'b0;
      external_data_ram_rd <= 1'b0;
      external_data_ram_addr <= 16'h0000;
      external_data_ram_wdata <= 8'h00;
    end else if (ce) begin
      external_data_ram_wr <= movx_wr && !store_write_enable_q;
      external_data_ram_rd <= movx_rd;
      if (movx_wr || movx_rd) begin
        external_data_ram_addr <= cpu_addr;
        external_data_ram_wdata <= cpu_wdata;
      end
    end
  end
endmodule // flash_byte_program_erase
`default_nettype wire

// ===== tb/flash_seq_chk.sv
/* Checker for the Flash store sequencer, bound to its top module.
   Assumes ce stays high and the operation counts are passed on. */
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.vh"
module flash_seq_chk #(
  parameter [18:0] ERASE_CYCLES = 19'h00258,
  parameter [18:0] WRITE_CYCLES = 19'h00014
) (
  // Clock, reset and register bus.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  // Processor side.
  input wire [15:0] cpu_addr,
  input wire movx_wr,
  input wire movx_rd,
  input wire movc_rd,
  input wire movc_valid,
  input wire cpu_stall,
  input wire [7:0] irq_out,
  // External RAM, debug port and strap.
  input wire external_data_ram_wr,
  input wire external_data_ram_rd,
  input wire dbg_wr,
  input wire dbg_erase,
  input wire flash_is_init
);
  logic [2:0] psc_q; // Mirror of the store control bits.
  logic allow_q; // Mirror of the write/erase allow bit.
  logic [19:0] len_q; // Cycles the core has been stalled so far.
  logic er_q; // The running operation is an erase.
  logic go; // A store reaches the sequencer while it is idle.
  assign go = movx_wr && !cpu_stall;
  // Mirror register writes and measure each stall.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_q <= 3'h0;
      allow_q <= 1'b0;
      len_q <= 20'h00000;
      er_q <= 1'b0;
    end else begin
      if (psel && penable && pwrite && paddr == `PSC_OFF)
        psc_q <= pwdata[2:0];
      if (psel && penable && pwrite && paddr == `FSC_OFF)
        allow_q <= pwdata[0];
      len_q <= cpu_stall ? len_q + 20'h00001 : 20'h00000;
      if (!cpu_stall)
        er_q <= dbg_erase || (!dbg_wr && psc_q[1]);
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_redirect;
    go && !psc_q[0] |=> external_data_ram_wr && !cpu_stall;
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("store missed external RAM");
  property p_load;
    movx_rd && !cpu_stall |=> external_data_ram_rd;
  endproperty
  a_load: assert property (p_load)
    else $error("load missed external RAM");
  property p_code;
    movc_rd && !cpu_stall |=> movc_valid ##1 !movc_valid;
  endproperty
  a_code: assert property (p_code)
    else $error("code read gave no single valid pulse");
  property p_no_allow;
    go && psc_q[0] && !allow_q |=> !cpu_stall [*2];
  endproperty
  a_no_allow: assert property (p_no_allow)
    else $error("store ran without allow bit");
  property p_lock;
    go && psc_q[1:0] == 2'h3 && cpu_addr[15:9] == `LOCK_PAGE |=> !cpu_stall;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock page erase started");
  property p_start;
    go && psc_q[0] && allow_q && flash_is_init
      && cpu_addr[15:9] != `LOCK_PAGE |=> cpu_stall;
  endproperty
  a_start: assert property (p_start)
    else $error("enabled store did not start an operation");
  property p_op_time;
    $fell(cpu_stall) |-> (er_q ? (len_q >= ERASE_CYCLES
      && len_q <= ERASE_CYCLES + 4) : (len_q >= WRITE_CYCLES
      && len_q <= WRITE_CYCLES + 3));
  endproperty
  a_op_time: assert property (p_op_time)
    else $error("operation length out of range");
  property p_irq_hold;
    cpu_stall |-> irq_out == 8'h00;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt passed during stall");
  c_erase: cover property ($fell(cpu_stall) && er_q);
  c_write: cover property ($fell(cpu_stall) && !er_q);
  c_lock: cover property (go && psc_q[1] && cpu_addr[15:9] == `LOCK_PAGE);
endmodule // flash_seq_chk
bind flash_byte_program_erase flash_seq_chk #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES)
) chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cpu_addr(cpu_addr),
  .movx_wr(movx_wr), .movx_rd(movx_rd), .movc_rd(movc_rd),
  .movc_valid(movc_valid), .cpu_stall(cpu_stall), .irq_out(irq_out),
  .external_data_ram_wr(external_data_ram_wr),
  .external_data_ram_rd(external_data_ram_rd), .dbg_wr(dbg_wr),
  .dbg_erase(dbg_erase), .flash_is_init(flash_is_init));
`default_nettype wire

// ===== tb/cpu_core_model.sv
/* Behavioural processor core: stores, loads and code reads.
   Assumes the sequencer samples strobes on the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  // Clock and stall.
  input wire logic pclk,
  input wire logic cpu_stall,
  // Address, data and strobes.
  output logic [15:0] cpu_addr,
  output logic [7:0] cpu_wdata,
  output logic movx_wr,
  output logic movx_rd,
  output logic movc_rd
);
  // Strobes are idle from time zero.
  initial begin
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    {movx_wr, movx_rd, movc_rd} = 3'h0;
  end
  // One strobe of kind 0 store, 1 load or 2 code read.
  task automatic issue(input int k, input logic [15:0] ad,
                       input logic [7:0] d);
    do @(posedge pclk); while (cpu_stall);
    cpu_addr <= ad;
    cpu_wdata <= d;
    movx_wr <= k == 0; // No handler runs, so no stray store.
    movx_rd <= k == 1;
    movc_rd <= k == 2;
    @(posedge pclk);
    {movx_wr, movx_rd, movc_rd} <= 3'h0;
    cpu_addr <= ~ad; // Released lines lose their old value.
    cpu_wdata <= ~d;
  endtask
endmodule // cpu_core_model
`default_nettype wire

// ===== tb/flash_byte_program_erase_tb_top.sv
/* Self-checking bench for the Flash store sequencer.
   Assumes shortened operation counts of 600 and 20 cycles. */
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.vh"
module flash_byte_program_erase_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, flash_is_init = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00, irq_in = 8'h00, dbg_wdata = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic dbg_wr = 1'b0, dbg_erase = 1'b0, pready, pslverr;
  logic [15:0] dbg_addr = 16'h0, cpu_addr, a, base;
  logic [7:0] cpu_wdata, movc_rdata, irq_out, b, c;
  logic movx_wr, movx_rd, movc_rd, movc_valid, cpu_stall;
  logic external_data_ram_wr, external_data_ram_rd;
  logic [15:0] external_data_ram_addr;
  logic [7:0] external_data_ram_wdata;
  logic [23:0] xa;
  int seed = 98, error_cnt = 0, compares = 0, xr = 0;
  always #12.5 pclk = ~pclk;
  flash_byte_program_erase #(.ERASE_CYCLES(19'h258),
    .WRITE_CYCLES(19'h14)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .movx_wr(movx_wr),
    .movx_rd(movx_rd), .movc_rd(movc_rd), .movc_rdata(movc_rdata),
    .movc_valid(movc_valid), .cpu_stall(cpu_stall), .irq_in(irq_in),
    .irq_out(irq_out), .external_data_ram_wr(external_data_ram_wr),
    .external_data_ram_rd(external_data_ram_rd),
    .external_data_ram_addr(external_data_ram_addr),
    .external_data_ram_wdata(external_data_ram_wdata), .dbg_wr(dbg_wr),
    .dbg_erase(dbg_erase), .dbg_scratch(1'b0), .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata), .flash_is_init(flash_is_init));
  cpu_core_model cpu (.pclk(pclk), .cpu_stall(cpu_stall),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .movx_wr(movx_wr),
    .movx_rd(movx_rd), .movc_rd(movc_rd));
  // Note what reaches the external RAM strobes.
  always @(posedge pclk) begin
    if (external_data_ram_wr === 1'b1)
      xa = {external_data_ram_addr, external_data_ram_wdata};
    if (external_data_ram_rd === 1'b1)
      xr++;
  end
  task automatic chk(input string nm, input logic [31:0] x, g);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, x, g);
    end
  endtask
  // One APB transfer; holds the request until pready.
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] ad,
                      input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(nm, x, r);
  endtask
  task automatic st(input logic [15:0] ad, input logic [7:0] d);
    cpu.issue(0, ad, d);
    do @(posedge pclk); while (cpu_stall);
  endtask
  task automatic fchk(input logic [15:0] ad, input logic [7:0] x);
    cpu.issue(2, ad, 8'h00);
    @(posedge pclk);
    chk("code byte", {1'b1, x}, {movc_valid, movc_rdata});
  endtask
  task automatic dbg(input logic er, input logic [15:0] ad,
                     input logic [7:0] d);
    @(posedge pclk);
    {dbg_addr, dbg_wdata, dbg_erase, dbg_wr} <= {ad, d, er, !er};
    @(posedge pclk);
    {dbg_erase, dbg_wr} <= 2'h0;
    do @(posedge pclk); while (cpu_stall);
  endtask
  task automatic rst(input logic s);
    presetn <= 1'b0;
    flash_is_init <= s;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Stop a hang; the run needs well under 0.3 ms.
  initial begin
    #1000000;
    error_cnt++;
    close_out();
  end
  initial begin
    rst(1'b0);
    apb(1'b1, `FSC_OFF, 32'h1);
    apb(1'b1, `PSC_OFF, 32'h1);
    st(16'h0200, 8'h00);
    rchk("status", `STAT_OFF, 32'h4);
    rst(1'b1);
    rchk("control", `PSC_OFF, 32'h0);
    rchk("scale", `FSC_OFF, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h1, {r[30:0], e});
    a = $random(seed);
    b = $random(seed);
    st(a, b);
    @(posedge pclk);
    chk("ram store", {a, b}, xa);
    apb(1'b1, `PSC_OFF, 32'h1);
    cpu.issue(1, a, 8'h00);
    repeat (2) @(posedge pclk);
    chk("ram loads", 32'h1, xr);
    $display("test redirect finished");
    apb(1'b1, `FSC_OFF, 32'h0);
    apb(1'b1, `PSC_OFF, 32'h3);
    st(a, b);
    rchk("status", `STAT_OFF, 32'h6);
    apb(1'b1, `STAT_OFF, 32'h4);
    apb(1'b1, `FSC_OFF, 32'h1);
    base = {7'(($random(seed) & 32'h3F) + 1), 9'h000};
    st(base | 16'h0123, 8'h00);
    apb(1'b1, `PSC_OFF, 32'h1);
    for (int i = 0; i < 4; i++) begin
      a = base + 16'(i * 128) + 16'($unsigned($random(seed)) % 127);
      b = $random(seed);
      c = $random(seed);
      st(a, b);
      st(a, c);
      fchk(a, b & c);
    end
    fchk(base | 16'h007F, 8'hFF);
    fchk(base | 16'h01FF, 8'hFF);
    rchk("control", `PSC_OFF, 32'h1);
    $display("test erase and program finished");
    dbg(1'b1, 16'hFC00, 8'h00);
    dbg(1'b0, 16'hFC10, 8'h3C);
    fchk(16'hFC10, 8'h3C);
    st(16'hFDFE, 8'h5A);
    apb(1'b1, `PSC_OFF, 32'h3);
    st(16'hFD00, 8'h00);
    rchk("status", `STAT_OFF, 32'h6);
    fchk(16'hFDFE, 8'h5A);
    $display("test lock page finished");
    st(16'h0000, 8'h00);
    apb(1'b1, `PSC_OFF, 32'h1);
    st(16'h0010, 8'hC3);
    apb(1'b1, `PSC_OFF, 32'h7);
    st(16'h0010, 8'h00);
    apb(1'b1, `PSC_OFF, 32'h5);
    st(16'h0010, 8'h33);
    fchk(16'h0010, 8'h33);
    fchk(16'h007F, 8'hFF);
    apb(1'b1, `PSC_OFF, 32'h1);
    fchk(16'h0010, 8'hC3);
    $display("test scratchpad finished");
    fork
      st(base | 16'h00FF, 8'h96);
      begin
        repeat (5) @(posedge pclk);
        irq_in <= 8'h05;
        @(posedge pclk);
        irq_in <= 8'h00;
      end
    join
    chk("held irq", 32'h05, irq_out);
    $display("test interrupts finished");
    close_out();
  end
endmodule // flash_byte_program_erase_tb_top
`default_nettype wire
